//--- bctm_regs.svh
// register map, control-word fields and timing counts of the counter block
// assumes a 40 MHz mclk and word-spaced registers on a 32-bit bus
`ifndef BCTM_REGS_SVH
`define BCTM_REGS_SVH

// register indices; byte address is four times the index
`define BCTM_IDX_DAC_LAST 5'h0f
`define BCTM_IDX_REFCTL 5'h10
`define BCTM_IDX_IRQEN 5'h11
`define BCTM_IDX_DACRST 5'h13
`define BCTM_IDX_CNT0 5'h14
`define BCTM_IDX_CNT1 5'h15
`define BCTM_IDX_CNT2 5'h16
`define BCTM_IDX_CTRL 5'h17
`define BCTM_IDX_IRQCLR 5'h1e

// reference-control and interrupt-enable bits
`define BCTM_BIT_REF 6
`define BCTM_BIT_GATE_OFF 1
`define BCTM_BIT_IRQEN 1

// control word fields
`define BCTM_CW_SEL 7:6
`define BCTM_CW_ACC 5:4
`define BCTM_CW_MODE 3:1
`define BCTM_CW_BCD 0
`define BCTM_CW_M1 2
`define BCTM_CW_MLO 2:1
`define BCTM_RB_CNT_N 5
`define BCTM_RB_STA_N 4
`define BCTM_RB_C0 1
`define BCTM_SEL_READBACK 2'h3
`define BCTM_ACC_LATCH 2'h0
`define BCTM_ACC_LSB 2'h1
`define BCTM_ACC_MSB 2'h2
`define BCTM_ACC_WORD 2'h3

// operating modes
`define BCTM_MODE0 3'h0
`define BCTM_MODE1 3'h1
`define BCTM_MODE2 3'h2
`define BCTM_MODE3 3'h3
`define BCTM_MODE4 3'h4
`define BCTM_MODE5 3'h5

// clock rates and derived prescaler counts
`define BCTM_MCLK_KHZ 40000
`define BCTM_CNT0_KHZ 10000
`define BCTM_CASC_KHZ 2000
`define BCTM_DIV0 5'((`BCTM_MCLK_KHZ / `BCTM_CNT0_KHZ) - 1)
`define BCTM_DIVC 5'((`BCTM_MCLK_KHZ / `BCTM_CASC_KHZ) - 1)

// conversion strobe: strictly under 100 ns
`define BCTM_CONV_NS 100
// preload is the low time in cycles minus the load cycle itself
`define BCTM_CONV_CYC 2'((`BCTM_CONV_NS * `BCTM_MCLK_KHZ) / 1000000 - 2)

`endif

//--- bctm_pkg.sv
// types shared by the counter block files
// assumes bctm_regs.svh supplies the numeric constants
package bctm_pkg;

  typedef enum logic [1:0] {
    BCTM_BUS_IDLE = 2'b01,
    BCTM_BUS_ACK = 2'b10
  } bctm_bus_t;

  typedef struct packed {
    logic [15:0] cr;
    logic [15:0] ce;
    logic [15:0] hold;
    logic [7:0] status;
    logic [2:0] mode;
    logic [1:0] acc;
    logic bcd;
    logic out;
    logic null_cnt;
    logic armed;
    logic load_pend;
    logic trig_pend;
    logic gate_prev;
    logic wr_msb;
    logic rd_msb;
    logic latched;
    logic status_pend;
  } bctm_chan_t;

  typedef struct packed {
    bctm_bus_t bus;
    logic waitreq;
    logic [31:0] rdata;
    logic ref_en;
    logic gate_off;
    logic irq_en;
    logic irq_pend;
    logic out0_prev;
    logic out1_prev;
    logic [4:0] pre0;
    logic [4:0] prec;
    logic conv_n;
    logic [1:0] conv_cnt;
    logic [2:0] dac_chan;
    logic [11:0] dac_val;
  } bctm_top_t;

endpackage : bctm_pkg

//--- bctm_chan.sv
// one 16-bit presettable down-counter with six modes, latch and status
// assumes tick is a one-cycle count pulse and bus strobes are one cycle
`include "bctm_regs.svh"

module bctm_chan (
  input wire logic mclk,
  input wire logic reset,
  input wire logic tick,
  input wire logic gate,
  input wire logic cw_wr,
  input wire logic data_wr,
  input wire logic rd,
  input wire logic latch_cnt,
  input wire logic latch_sta,
  input wire logic [7:0] wdata,
  output logic out_level,
  output logic [7:0] rd_byte
);
  import bctm_pkg::*;

  bctm_chan_t s_r;
  bctm_chan_t s_nxt;
  logic go;
  logic done;
  logic [15:0] src;

  always_comb begin
    s_nxt = s_r;
    done = 1'b0;
    s_nxt.gate_prev = gate;
    if (gate && !s_r.gate_prev) begin
      s_nxt.trig_pend = 1'b1; // RULE14
    end
    if (s_r.mode == `BCTM_MODE1 || s_r.mode == `BCTM_MODE5) begin
      go = s_r.trig_pend;
    end else if (s_r.mode == `BCTM_MODE2 || s_r.mode == `BCTM_MODE3) begin
      go = s_r.load_pend || s_r.trig_pend;
    end else begin
      go = s_r.load_pend;
    end
    if (tick) begin
      if ((s_r.mode == `BCTM_MODE4 || s_r.mode == `BCTM_MODE5) && !s_r.out) begin
        s_nxt.out = 1'b1; // RULE12 RULE13
      end
      if (go) begin
        // odd square-wave count starts its high half one count longer
        s_nxt.ce = (s_r.mode == `BCTM_MODE3 && s_r.cr[0]) ?
                   s_r.cr + 16'h0001 : s_r.cr; // RULE10
        s_nxt.armed = 1'b1;
        s_nxt.null_cnt = 1'b0;
        s_nxt.load_pend = 1'b0;
        s_nxt.trig_pend = 1'b0;
        if (s_r.mode == `BCTM_MODE1) begin
          s_nxt.out = 1'b0; // RULE8
        end else if (s_r.mode != `BCTM_MODE0) begin
          s_nxt.out = 1'b1;
        end
      end else if (s_r.armed && (gate || s_r.mode == `BCTM_MODE1 ||
                                 s_r.mode == `BCTM_MODE5)) begin
        case (s_r.mode)
          `BCTM_MODE0: begin
            s_nxt.ce = s_r.ce - 16'h0001;
            if (s_r.ce == 16'h0001) begin
              s_nxt.out = 1'b1; // RULE7
            end
          end
          `BCTM_MODE1: begin
            s_nxt.ce = s_r.ce - 16'h0001;
            if (s_r.ce == 16'h0001) begin
              s_nxt.out = 1'b1; // RULE8
              s_nxt.armed = 1'b0;
            end
          end
          `BCTM_MODE2: begin
            if (s_r.ce == 16'h0001) begin
              s_nxt.ce = s_r.cr; // RULE9
              s_nxt.out = 1'b1;
            end else begin
              s_nxt.ce = s_r.ce - 16'h0001;
              if (s_r.ce == 16'h0002) begin
                s_nxt.out = 1'b0; // RULE9
              end
            end
          end
          `BCTM_MODE3: begin
            if (s_r.ce == 16'h0002) begin
              s_nxt.out = !s_r.out;
              if (!s_r.cr[0]) begin
                s_nxt.ce = s_r.cr; // RULE11
              end else if (s_r.out) begin
                s_nxt.ce = s_r.cr - 16'h0001; // RULE10
              end else begin
                s_nxt.ce = s_r.cr + 16'h0001; // RULE10
              end
            end else begin
              s_nxt.ce = s_r.ce - 16'h0002; // RULE11
            end
          end
          default: begin
            s_nxt.ce = s_r.ce - 16'h0001;
            if (s_r.ce == 16'h0001) begin
              s_nxt.out = 1'b0; // RULE12 RULE13
              s_nxt.armed = 1'b0;
            end
          end
        endcase
      end
    end
    // periodic modes park high while the gate is low
    if (!gate && (s_r.mode == `BCTM_MODE2 || s_r.mode == `BCTM_MODE3)) begin
      s_nxt.out = 1'b1; // RULE9
    end
    if (cw_wr) begin
      // modes 6 and 7 fold onto 2 and 3, so the top mode bit is ignored whenever mode bit 1 is set
      s_nxt.mode = wdata[`BCTM_CW_M1] ? {1'b0, wdata[`BCTM_CW_MLO]} :
                   wdata[`BCTM_CW_MODE];
      s_nxt.acc = wdata[`BCTM_CW_ACC];
      s_nxt.bcd = wdata[`BCTM_CW_BCD];
      s_nxt.out = (wdata[`BCTM_CW_MODE] != `BCTM_MODE0); // RULE7
      s_nxt.armed = 1'b0;
      s_nxt.null_cnt = 1'b1;
      s_nxt.load_pend = 1'b0;
      s_nxt.trig_pend = 1'b0;
      s_nxt.wr_msb = 1'b0;
      s_nxt.rd_msb = 1'b0;
      s_nxt.latched = 1'b0;
      s_nxt.status_pend = 1'b0;
    end
    if (latch_cnt && !s_r.latched) begin
      s_nxt.hold = s_r.ce; // RULE19 RULE20
      s_nxt.latched = 1'b1;
    end
    if (latch_sta && !s_r.status_pend) begin
      s_nxt.status = {s_r.out, s_r.null_cnt, s_r.acc, s_r.mode, s_r.bcd}; // RULE20
      s_nxt.status_pend = 1'b1;
    end
    if (data_wr) begin
      case (s_r.acc)
        `BCTM_ACC_LSB: begin
          s_nxt.cr = {8'h00, wdata};
          done = 1'b1;
        end
        `BCTM_ACC_MSB: begin
          s_nxt.cr = {wdata, 8'h00};
          done = 1'b1;
        end
        default: begin
          if (!s_r.wr_msb) begin
            s_nxt.cr[7:0] = wdata;
            s_nxt.wr_msb = 1'b1;
          end else begin
            s_nxt.cr[15:8] = wdata;
            s_nxt.wr_msb = 1'b0;
            done = 1'b1;
          end
        end
      endcase
      if (done) begin
        s_nxt.load_pend = 1'b1; // RULE1 RULE2
        s_nxt.null_cnt = 1'b1;
        if (s_r.mode == `BCTM_MODE0) begin
          s_nxt.out = 1'b0; // RULE7
        end
      end
    end
    if (rd) begin
      if (s_r.status_pend) begin
        s_nxt.status_pend = 1'b0; // RULE20
      end else if (s_r.acc != `BCTM_ACC_WORD || s_r.rd_msb) begin
        s_nxt.rd_msb = 1'b0;
        s_nxt.latched = 1'b0; // RULE19
      end else begin
        s_nxt.rd_msb = 1'b1;
      end
    end
  end

  always_comb begin
    src = s_r.latched ? s_r.hold : s_r.ce;
    if (s_r.status_pend) begin
      rd_byte = s_r.status;
    end else if (s_r.acc == `BCTM_ACC_MSB ||
                 (s_r.acc == `BCTM_ACC_WORD && s_r.rd_msb)) begin
      rd_byte = src[15:8];
    end else begin
      rd_byte = src[7:0];
    end
  end

  assign out_level = s_r.out;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.out <= 1'b1;
      // gates idle high, so no false trigger follows reset
      s_r.gate_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : bctm_chan

//--- bctm_top.sv
// board counter/timer block: three counters, dac write strobe, reg file
// assumes an Avalon-MM master with byte addresses, one register per word
//
// Behaviour
// RULE1: three separately programmable 16-bit presettable down-counters
// RULE2: binary divisor 2..65535 divides input clock
// RULE3: counter 0 runs at 10MHz, drives tick pin
// RULE4: bit 1 at 10h high stops counters 1,2; in modes 1 and 5 they keep counting
// RULE5: counters 1 and 2 chained, 32 bits, 2MHz
// RULE6: counter 0 output raises periodic tick interrupts
// RULE7: mode 0 load lowers output, high at zero
// RULE8: mode 1 retriggerable one-shot, low until zero
// RULE9: mode 2 one-period low pulse every N counts
// RULE10: mode 3 square wave, odd count high longer
// RULE11: mode 3 decrements by two each half-wave
// RULE12: mode 4 software strobe, gate low inhibits
// RULE13: mode 5 gate-triggered strobe, retriggerable
// RULE14: trigger is gate rising edge, tick counts
// RULE15: short low conversion strobe on each update
// RULE16: dac data writes take effect immediately
// RULE17: control byte selects counter, access, mode, bcd
// RULE18: counter data ports at 14, 15, 16
// RULE19: latch holds count until it is read
// RULE20: readback latches counts and status together
// RULE21: counter 0 gate held permanently enabled
`include "bctm_regs.svh"

module bctm_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic tick_out,
  output logic cascade_out,
  output logic irq,
  output logic conv_strobe_n,
  output logic ref_enable,
  output logic [2:0] dac_chan,
  output logic [11:0] dac_value
);
  import bctm_pkg::*;

  bctm_top_t s_r;
  bctm_top_t s_nxt;
  logic [4:0] idx;
  logic done;
  logic [7:0] wbyte;
  logic [2:0] out;
  logic [2:0] tick;
  logic [2:0] gate;
  logic [7:0] rd_byte [3];
  logic [2:0] cw_wr;
  logic [2:0] data_wr;
  logic [2:0] rd;
  logic [2:0] latch_cnt;
  logic [2:0] latch_sta;
  logic readback;

  assign idx = avs_address[6:2];
  assign wbyte = avs_writedata[7:0];
  // the access completes on the edge that sees waitrequest low
  assign done = (s_r.bus == BCTM_BUS_ACK);
  assign readback = (wbyte[`BCTM_CW_SEL] == `BCTM_SEL_READBACK);

  assign tick[0] = (s_r.pre0 == `BCTM_DIV0); // RULE3
  assign tick[1] = (s_r.prec == `BCTM_DIVC); // RULE5
  // the upper half counts once per rising edge of the lower half's output
  assign tick[2] = out[1] && !s_r.out1_prev; // RULE5
  assign gate[0] = 1'b1; // RULE21
  assign gate[1] = !s_r.gate_off; // RULE4
  assign gate[2] = !s_r.gate_off; // RULE4

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cw_wr[i] = 1'b0;
      data_wr[i] = 1'b0;
      rd[i] = 1'b0;
      latch_cnt[i] = 1'b0;
      latch_sta[i] = 1'b0;
    end
    if (done && avs_write && idx == `BCTM_IDX_CTRL) begin
      for (int i = 0; i < 3; i++) begin
        if (readback) begin
          latch_cnt[i] = wbyte[`BCTM_RB_C0 + i] &&
                         !wbyte[`BCTM_RB_CNT_N]; // RULE20
          latch_sta[i] = wbyte[`BCTM_RB_C0 + i] &&
                         !wbyte[`BCTM_RB_STA_N]; // RULE20
        end else if (wbyte[`BCTM_CW_SEL] == 2'(i)) begin
          latch_cnt[i] = (wbyte[`BCTM_CW_ACC] == `BCTM_ACC_LATCH); // RULE19
          cw_wr[i] = (wbyte[`BCTM_CW_ACC] != `BCTM_ACC_LATCH); // RULE17
        end
      end
    end
    for (int i = 0; i < 3; i++) begin
      if (done && idx == `BCTM_IDX_CNT0 + 5'(i)) begin
        data_wr[i] = avs_write; // RULE18
        rd[i] = avs_read; // RULE18
      end
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_chan
    bctm_chan u_chan (
      .mclk(mclk),
      .reset(reset),
      .tick(tick[g]),
      .gate(gate[g]),
      .cw_wr(cw_wr[g]),
      .data_wr(data_wr[g]),
      .rd(rd[g]),
      .latch_cnt(latch_cnt[g]),
      .latch_sta(latch_sta[g]),
      .wdata(wbyte),
      .out_level(out[g]),
      .rd_byte(rd_byte[g])
    );
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.out0_prev = out[0];
    s_nxt.out1_prev = out[1];
    s_nxt.pre0 = tick[0] ? 5'h00 : s_r.pre0 + 5'h01;
    s_nxt.prec = tick[1] ? 5'h00 : s_r.prec + 5'h01;

    // strobe: low for a fixed number of cycles, kept under 100 ns
    if (!s_r.conv_n) begin
      if (s_r.conv_cnt == 2'h0) begin
        s_nxt.conv_n = 1'b1;
      end else begin
        s_nxt.conv_n = 1'b0;
        s_nxt.conv_cnt = s_r.conv_cnt - 2'h1;
      end
    end

    // bus handshake: one wait cycle, then the answer
    case (s_r.bus)
      BCTM_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          s_nxt.bus = BCTM_BUS_ACK;
          s_nxt.waitreq = 1'b0;
          s_nxt.rdata = 32'h0000_0000;
          if (avs_read) begin
            if (idx == `BCTM_IDX_REFCTL) begin
              s_nxt.rdata[`BCTM_BIT_REF] = s_r.ref_en;
              s_nxt.rdata[`BCTM_BIT_GATE_OFF] = s_r.gate_off;
            end else if (idx == `BCTM_IDX_IRQEN) begin
              s_nxt.rdata[`BCTM_BIT_IRQEN] = s_r.irq_en;
            end else if (idx == `BCTM_IDX_CNT0) begin
              s_nxt.rdata[7:0] = rd_byte[0];
            end else if (idx == `BCTM_IDX_CNT1) begin
              s_nxt.rdata[7:0] = rd_byte[1];
            end else if (idx == `BCTM_IDX_CNT2) begin
              s_nxt.rdata[7:0] = rd_byte[2];
            end
          end
        end
      end
      BCTM_BUS_ACK: begin
        s_nxt.bus = BCTM_BUS_IDLE;
        s_nxt.waitreq = 1'b1;
      end
      default: begin
        s_nxt.bus = BCTM_BUS_IDLE;
        s_nxt.waitreq = 1'b1;
      end
    endcase

    if (done && avs_write) begin
      if (idx <= `BCTM_IDX_DAC_LAST) begin
        s_nxt.dac_chan = idx[3:1]; // RULE16
        if (idx[0]) begin
          s_nxt.dac_val[11:8] = avs_writedata[3:0];
        end else begin
          s_nxt.dac_val = avs_writedata[11:0];
        end
        s_nxt.conv_n = 1'b0; // RULE15
        s_nxt.conv_cnt = `BCTM_CONV_CYC;
      end else if (idx == `BCTM_IDX_REFCTL) begin
        s_nxt.ref_en = avs_writedata[`BCTM_BIT_REF];
        s_nxt.gate_off = avs_writedata[`BCTM_BIT_GATE_OFF]; // RULE4
      end else if (idx == `BCTM_IDX_IRQEN) begin
        s_nxt.irq_en = avs_writedata[`BCTM_BIT_IRQEN];
      end else if (idx == `BCTM_IDX_DACRST) begin
        s_nxt.dac_val = 12'h000;
        s_nxt.conv_n = 1'b0; // RULE15
        s_nxt.conv_cnt = `BCTM_CONV_CYC;
      end else if (idx == `BCTM_IDX_IRQCLR) begin
        s_nxt.irq_pend = 1'b0;
      end
    end

    // a falling edge of counter 0 in the clear cycle still sets the flag
    if (s_r.irq_en && s_r.out0_prev && !out[0]) begin
      s_nxt.irq_pend = 1'b1; // RULE6
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.bus <= BCTM_BUS_IDLE;
      s_r.waitreq <= 1'b1;
      s_r.conv_n <= 1'b1;
      s_r.out0_prev <= 1'b1;
      s_r.out1_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.waitreq;
  assign tick_out = out[0]; // RULE3
  assign cascade_out = out[2];
  assign irq = s_r.irq_pend;
  assign conv_strobe_n = s_r.conv_n;
  assign ref_enable = s_r.ref_en;
  assign dac_chan = s_r.dac_chan;
  assign dac_value = s_r.dac_val;

endmodule : bctm_top

//--- bctm_props.sv
// checker for bus timing, conversion strobe and tick interrupt ports
// assumes it is bound to bctm_top and sees only that module's ports
module bctm_props (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic tick_out,
  input wire logic irq,
  input wire logic conv_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [4:0] idx;
  logic ack_wr;
  logic ack_rd;
  assign idx = avs_address[6:2];
  assign ack_wr = avs_write && !avs_waitrequest;
  assign ack_rd = avs_read && !avs_waitrequest;

  chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_req_answer: assert property ($rose(avs_read || avs_write)
    |=> !avs_waitrequest) else $error("request not answered in one cycle");
  chk_unmapped_zero: assert property (ack_rd && (idx == 5'h12
    || (idx >= 5'h18 && idx <= 5'h1d) || idx == 5'h1f)
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_cnt_byte: assert property (ack_rd && idx >= 5'h14 && idx <= 5'h16
    |-> avs_readdata[31:8] == 24'h0) else $error("counter port not a byte");
  chk_dac_strobe: assert property (ack_wr && idx <= 5'h0f
    |=> !conv_strobe_n) else $error("dac write gave no strobe");
  chk_strobe_width: assert property ($fell(conv_strobe_n)
    |-> !conv_strobe_n [*3] ##1 conv_strobe_n)
    else $error("strobe not three cycles long");
  chk_strobe_cause: assert property ($fell(conv_strobe_n)
    |-> $past(ack_wr && (idx <= 5'h0f || idx == 5'h13)))
    else $error("strobe without write");
  chk_irq_set: assert property ($rose(irq)
    |-> !$past(tick_out) && $past(tick_out, 2))
    else $error("irq rose without tick fall");
  chk_irq_clear: assert property (ack_wr && idx == 5'h1e
    && !$fell(tick_out) |=> !irq) else $error("irq not cleared");
endmodule : bctm_props

//--- bctm_host.sv
// avalon-mm master standing in for the host processor
// assumes the slave answers by dropping waitrequest at a rising edge
module bctm_host (
  input wire logic mclk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [6:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    avs_address = 7'h00;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    hung = 1'h0;
  end

  // request is held until waitrequest is sampled low, then released
  task xfer(input logic rd, input logic [4:0] idx, input logic [31:0] wd,
            output logic [31:0] q);
    int n;
    @(posedge mclk);
    avs_address <= {idx, 2'h0};
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 64);
    q = avs_readdata;
    if (avs_waitrequest !== 1'h0) hung = 1'h1;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : xfer
endmodule : bctm_host

//--- tb.sv
// self-checking bench driving the counter block through its register bus
// assumes bctm_host as bus master and bctm_props bound to bctm_top
`include "bctm_regs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D0 = `BCTM_MCLK_KHZ / `BCTM_CNT0_KHZ;
  localparam int DC = `BCTM_MCLK_KHZ / `BCTM_CASC_KHZ;
  logic mclk, reset, avs_read, avs_write, avs_waitrequest, hung;
  logic tick_out, cascade_out, irq, conv_strobe_n, ref_enable;
  logic [6:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0] dac_chan;
  logic [11:0] dac_value;
  int n_fail, checks, w, lo, hi;

  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  bctm_top dut (.mclk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .tick_out, .cascade_out,
    .irq, .conv_strobe_n, .ref_enable, .dac_chan, .dac_value);
  bctm_host host (.mclk, .avs_waitrequest, .avs_readdata, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .hung);

  task close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task wr(input logic [4:0] idx, input logic [31:0] d);
    host.xfer(1'h0, idx, d, q);
    if (hung !== 1'h0) begin
      n_fail++;
      close_out;
    end
  endtask : wr

  task rd(input logic [4:0] idx, input logic [31:0] e);
    host.xfer(1'h1, idx, 32'h0, q);
    if (hung !== 1'h0) begin
      n_fail++;
      close_out;
    end
    cmp(q, e);
  endtask : rd

  // sel picks cascade_out over tick_out; bound stops a dead output hanging
  task wait_lvl(input logic sel, input logic lvl, output int n);
    n = 0;
    while ((sel ? cascade_out : tick_out) !== lvl && n < 600) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 600) begin
      n_fail++;
      close_out;
    end
  endtask : wait_lvl

  task measure(input logic sel, output int l, output int h);
    wait_lvl(sel, 1'h0, w);
    wait_lvl(sel, 1'h1, l);
    wait_lvl(sel, 1'h0, h);
  endtask : measure

  initial begin
    reset = 1'h1;
    n_fail = 0;
    checks = 0;
    repeat (16) @(posedge mclk);
    cmp({avs_waitrequest, tick_out, cascade_out, irq, conv_strobe_n,
         ref_enable, dac_chan, dac_value}, 21'h1d_0000);
    cmp(avs_readdata, 32'h0);
    reset <= 1'h0;
    wr(5'h10, 32'h42);
    rd(5'h10, 32'h42);
    cmp(ref_enable, 1'h1);
    rd(5'h12, 32'h0);
    rd(5'h11, 32'h0);
    wr(5'h04, 32'habc);
    repeat (2) @(posedge mclk);
    cmp({dac_chan, dac_value}, {3'h2, 12'habc});
    wr(5'h05, 32'h7);
    repeat (2) @(posedge mclk);
    cmp({dac_chan, dac_value}, {3'h2, 12'h7bc});
    wr(5'h13, 32'hfff);
    repeat (2) @(posedge mclk);
    cmp(dac_value, 12'h000);
    // counter 1 loaded while gated off must hold its count
    wr(5'h17, 32'h70);
    wr(5'h15, 32'h03);
    wr(5'h15, 32'h00);
    repeat (4 * DC) @(posedge mclk);
    wr(5'h17, 32'h40);
    rd(5'h15, 32'h03);
    rd(5'h15, 32'h00);
    wr(5'h17, 32'hc4);
    rd(5'h15, 32'h30);
    rd(5'h15, 32'h03);
    rd(5'h15, 32'h00);
    wr(5'h10, 32'h40);
    repeat (6 * DC) @(posedge mclk);
    wr(5'h17, 32'he4);
    rd(5'h15, 32'hb0);
    for (int m = 2; m <= 3; m++) begin
      for (int k = 2; k <= 5; k++) begin
        wr(5'h17, {2'h0, 2'h3, 3'(m), 1'h0});
        wr(5'h14, k);
        wr(5'h14, 0);
        repeat (2) measure(1'h0, lo, hi);
        cmp(lo, m == 2 ? D0 : (k / 2) * D0);
        cmp(hi, m == 2 ? (k - 1) * D0 : ((k + 1) / 2) * D0);
      end
    end
    wr(5'h11, 32'h2);
    rd(5'h11, 32'h2);
    measure(1'h0, lo, hi);
    // the flag is registered one edge after the fall is first seen
    @(posedge mclk);
    cmp(irq, 1'h1);
    wr(5'h1e, 32'h0);
    @(posedge mclk);
    cmp(irq, 1'h0);
    wr(5'h11, 32'h0);
    repeat (2) measure(1'h0, lo, hi);
    cmp(irq, 1'h0);
    // cascade: counter 1 and 2 both divide by two
    wr(5'h17, 32'h74);
    wr(5'h15, 32'h02);
    wr(5'h15, 32'h00);
    wr(5'h17, 32'hb4);
    wr(5'h16, 32'h02);
    wr(5'h16, 32'h00);
    repeat (2) measure(1'h1, lo, hi);
    cmp(lo + hi, 4 * DC);
    cmp(lo, 2 * DC);
    wr(5'h10, 32'h42);
    repeat (10 * DC) @(posedge mclk);
    cmp(cascade_out, 1'h1);
    wr(5'h17, 32'h38);
    wr(5'h14, 32'h03);
    wr(5'h14, 32'h00);
    wait_lvl(1'h0, 1'h0, w);
    wait_lvl(1'h0, 1'h1, lo);
    // one shot only: the output must then stay high without a reload
    hi = 0;
    repeat (600) begin
      @(posedge mclk);
      if (tick_out === 1'h1) hi++;
    end
    cmp(lo, D0);
    cmp(hi, 600);
    wr(5'h17, 32'h30);
    @(posedge mclk);
    cmp(tick_out, 1'h0);
    wr(5'h14, 32'h08);
    wr(5'h14, 32'h00);
    wait_lvl(1'h0, 1'h1, w);
    cmp(w >= 7 * D0 && w <= 10 * D0, 1'h1);
    for (int i = 0; i < 2; i++) begin
      wr(5'h17, i ? 32'h3a : 32'h32);
      wr(5'h14, 32'h03);
      wr(5'h14, 32'h00);
      repeat (20 * D0) @(posedge mclk);
      cmp(tick_out, 1'h1);
    end
    close_out;
  end
endmodule : tb

bind bctm_top bctm_props u_props (.mclk, .reset, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .tick_out, .irq,
  .conv_strobe_n);
